/* design/adc_ctrl_pkg.sv */
// shared constants and types for the two-channel converter serial control
package adc_ctrl_pkg;

  localparam int RES_BITS = 12; // result width, 4096 codes
  localparam int CTRL_BITS = 8; // control word width
  localparam int FIFO_DEPTH = 32; // sample buffer depth
  localparam int SEL_LOW_BIT = 3; // input select bit in control word
  localparam int SYNC_STAGES = 3; // pin synchroniser depth
  localparam int CNT_W = 5;

  localparam logic [CNT_W-1:0] CONV_CYCLES = 5'h10; // clocks per conversion
  localparam logic [CNT_W-1:0] TRACK_LAST = 5'h03; // last tracking cycle
  localparam logic [CNT_W-1:0] HOLD_FALL = 5'h04; // falling edge that holds
  localparam logic [CNT_W-1:0] DATA_FALL = 5'h05; // first result bit edge
  localparam logic [CNT_W-1:0] CTRL_LAST = 5'h08; // rising edges for word
  localparam logic CHAN_DEFAULT = 1'h0; // first input after reset

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_ACTIVE} phase_t;

endpackage

/* design/sample_if.sv */
// sample stream carrier between the converter control and its buffer
`timescale 1ns/1ps
interface sample_if #(parameter int W = 12);
  logic [W-1:0] inData;
  logic inValid;
  logic inReady;
  logic [W-1:0] outData;
  logic outValid;
  logic outReady;

  modport buffer (
    input inData, inValid, outReady,
    output inReady, outData, outValid
  );
  modport user (
    output inData, inValid, outReady,
    input inReady, outData, outValid
  );
endinterface

/* design/sample_fifo.sv */
// parameterised valid/ready fifo holding digitised samples
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  sample_if.buffer port
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic inRdy;
    logic outVld;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = port.inValid && q.inRdy;
  assign pop = port.outReady && q.outVld;
  assign port.inReady = q.inRdy;
  assign port.outValid = q.outVld;
  assign port.outData = mem[q.rp];

  // flags are registered so ready and valid never glitch
  always_comb begin
    d = q;
    if (push) begin
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    case ({push, pop})
      2'h2: d.cnt = q.cnt + 1'b1;
      2'h1: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    d.inRdy = d.cnt != (AW+1)'(DEPTH);
    d.outVld = d.cnt != '0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '{wp: '0, rp: '0, cnt: '0, inRdy: 1'b1, outVld: 1'b0};
    end else begin
      q <= d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[q.wp] <= port.inData;
    end
  end
endmodule

/* design/adc_serial_ctrl.sv */
// serial framing, channel select and result shifter of the converter
`timescale 1ns/1ps
module adc_serial_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = RES_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic doutOeN,
  output logic muxSelect,
  output logic tracking,
  output logic powered,
  input wire logic [WIDTH-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sclkSync;
    logic [SYNC_STAGES-1:0] csSync;
    logic [SYNC_STAGES-1:0] dinSync;
    logic sclkLvl;
    logic csLvl;
    phase_t phase;
    logic [CNT_W-1:0] riseCnt;
    logic [CNT_W-1:0] fallCnt;
    logic [CTRL_BITS-1:0] ctrlShift;
    logic nextSel;
    logic muxSel;
    logic [WIDTH-1:0] result;
    logic doutBit;
    logic doutOeN;
    logic tracking;
    logic powered;
    logic popReq;
  } state_t;

  state_t q;
  state_t d;
  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;
  logic [CTRL_BITS-1:0] ctrlWord;
  logic [CNT_W-1:0] fallNext;

  sample_if #(.W(WIDTH)) samples ();

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) buffer (
    .clock(clock),
    .rst(rst),
    .port(samples.buffer)
  );

  // source stalls on sampleReady once the buffer fills
  assign samples.inData = sampleData;
  assign samples.inValid = sampleValid;
  assign samples.outReady = q.popReq;
  assign sampleReady = samples.inReady;

  // edges count only once stages two and three agree
  assign sclkRise = (q.sclkSync[2] == q.sclkSync[1]) && q.sclkSync[2]
                    && !q.sclkLvl;
  assign sclkFall = (q.sclkSync[2] == q.sclkSync[1]) && !q.sclkSync[2]
                    && q.sclkLvl;
  assign csFall = (q.csSync[2] == q.csSync[1]) && !q.csSync[2] && q.csLvl;
  assign csRise = (q.csSync[2] == q.csSync[1]) && q.csSync[2] && !q.csLvl;
  assign ctrlWord = {q.ctrlShift[CTRL_BITS-2:0], q.dinSync[2]};
  assign fallNext = q.fallCnt + 1'b1;

  assign dout = q.doutBit;
  assign doutOeN = q.doutOeN;
  assign muxSelect = q.muxSel;
  assign tracking = q.tracking;
  assign powered = q.powered;

  // first conversion step, shared by frame start and back-to-back
  function automatic state_t start_conv(state_t s);
    state_t r;
    r = s;
    r.phase = PH_ACTIVE;
    r.fallCnt = 5'h01;
    r.riseCnt = 5'h00;
    r.muxSel = s.nextSel;
    r.tracking = 1'b1;
    r.powered = 1'b1;
    r.doutBit = 1'b0;
    r.doutOeN = 1'b0;
    return r;
  endfunction

  // framing and conversion sequencing
  always_comb begin
    d = q;
    d.sclkSync = {q.sclkSync[1:0], sclk};
    d.csSync = {q.csSync[1:0], csN};
    d.dinSync = {q.dinSync[1:0], din};
    if (q.sclkSync[2] == q.sclkSync[1]) begin
      d.sclkLvl = q.sclkSync[2];
    end
    if (q.csSync[2] == q.csSync[1]) begin
      d.csLvl = q.csSync[2];
    end
    d.popReq = 1'b0;
    case (q.phase)
      PH_IDLE: begin
        // a low clock at frame start counts as the first falling edge
        if (csFall && !q.sclkLvl) begin
          d = start_conv(d);
        end else if (csFall) begin
          d.phase = PH_WAIT;
          d.powered = 1'b1;
          d.doutOeN = 1'b0;
          d.doutBit = 1'b0;
        end
      end
      PH_WAIT: begin
        if (csRise) begin
          d.phase = PH_IDLE;
          d.powered = 1'b0;
          d.doutOeN = 1'b1;
        end else if (sclkFall) begin
          d = start_conv(d);
        end
      end
      PH_ACTIVE: begin
        if (csRise) begin
          // frame end abandons the conversion in flight
          d.phase = PH_IDLE;
          d.powered = 1'b0;
          d.tracking = 1'b0;
          d.doutOeN = 1'b1;
        end else begin
          if (sclkRise && q.riseCnt < CONV_CYCLES) begin
            d.riseCnt = q.riseCnt + 1'b1;
            if (q.riseCnt < CTRL_LAST) begin
              d.ctrlShift = ctrlWord;
            end
            if (d.riseCnt == CTRL_LAST) begin
              // only the lowest select bit steers the mux
              d.nextSel = ctrlWord[SEL_LOW_BIT];
            end
          end
          if (sclkFall && q.riseCnt == CONV_CYCLES) begin
            d = start_conv(d);
          end else if (sclkFall && q.fallCnt < CONV_CYCLES) begin
            d.fallCnt = fallNext;
            if (fallNext == HOLD_FALL) begin
              // empty buffer converts to code zero
              d.tracking = 1'b0;
              d.result = samples.outValid ? samples.outData : '0;
              d.popReq = samples.outValid;
            end
            if (fallNext >= DATA_FALL) begin
              d.doutBit = q.result[WIDTH-1];
              d.result = {q.result[WIDTH-2:0], 1'b0};
            end
            if (fallNext == CONV_CYCLES) begin
              d.powered = 1'b0;
            end
          end
        end
      end
      default: begin
        d.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '{sclkSync: '0, csSync: '1, dinSync: '0, sclkLvl: 1'b0,
             csLvl: 1'b1, phase: PH_IDLE, riseCnt: '0, fallCnt: '0,
             ctrlShift: '0, nextSel: CHAN_DEFAULT, muxSel: CHAN_DEFAULT,
             result: '0, doutBit: 1'b0, doutOeN: 1'b1, tracking: 1'b0,
             powered: 1'b0, popReq: 1'b0};
    end else begin
      q <= d;
    end
  end

  // checks on framing, select timing and the output shifter
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_release;
    $rose(q.csLvl) |-> q.doutOeN && !q.powered;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released at frame end");

  property p_idle_high;
    q.csLvl |-> q.phase == PH_IDLE && !q.tracking;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("activity while frame select high");

  property p_gap_down;
    (q.phase == PH_ACTIVE && q.fallCnt == CONV_CYCLES) |-> !q.powered;
  endproperty
  a_gap_down: assert property (p_gap_down)
    else $error("powered after last falling edge");

  property p_track;
    (q.phase == PH_ACTIVE && q.fallCnt >= 5'h01 && q.fallCnt <= TRACK_LAST)
      |-> q.tracking && q.powered;
  endproperty
  a_track: assert property (p_track)
    else $error("not tracking in first three cycles");

  property p_msb;
    (q.fallCnt == DATA_FALL && $past(q.fallCnt) == HOLD_FALL)
      |-> q.doutBit == $past(q.result[WIDTH-1]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("msb not on fifth clock");

  property p_lead_zero;
    (q.phase == PH_ACTIVE && q.fallCnt <= HOLD_FALL) |-> !q.doutBit;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("output not zero before result");

  property p_sel_take;
    (q.riseCnt == CTRL_LAST && $past(q.riseCnt) != CTRL_LAST)
      |-> q.nextSel == q.ctrlShift[SEL_LOW_BIT];
  endproperty
  a_sel_take: assert property (p_sel_take)
    else $error("select bit not taken from word");

  property p_sel_hold;
    (q.fallCnt > 5'h01 && $past(q.fallCnt) > 5'h01) |-> $stable(q.muxSel);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("channel changed inside conversion");

  property p_next_conv;
    (q.phase == PH_ACTIVE && q.riseCnt == CONV_CYCLES && sclkFall && !csRise)
      |=> q.fallCnt == 5'h01 && q.riseCnt == 5'h00 && q.tracking;
  endproperty
  a_next_conv: assert property (p_next_conv)
    else $error("back to back conversion not started");

  property p_cnt_max;
    q.riseCnt <= CONV_CYCLES && q.fallCnt <= CONV_CYCLES;
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("conversion longer than sixteen clocks");

  c_conv_end: cover property (q.fallCnt == CONV_CYCLES && q.powered == 1'b0);
  c_back: cover property (sclkFall && q.riseCnt == CONV_CYCLES && !csRise);
  c_pop: cover property (q.popReq);
  c_second: cover property (q.muxSel && q.tracking);
endmodule

/* bench/host_port_model.sv */
// host serial port model: frame select, serial clock and control bits
`timescale 1ns/1ps
module host_port_model (
  input wire logic clock,
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic pinDout
);
  // 6 clocks a level: slow enough for the pin synchronisers
  localparam int HALF = 6;
  logic [7:0] ctrlQ[$];
  logic [15:0] frameQ[$];
  // idle state: frame released, serial clock parked low
  initial begin
    csN = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
  end
  task automatic halfWait();
    repeat (HALF) @(negedge clock);
  endtask
  // n conversions of 16 clocks; stopAt cuts the frame after that rise
  task automatic runFrame(input int n, input bit startHigh, input int stopAt);
    logic [15:0] bits;
    logic [7:0] word;
    sclk = startHigh;
    halfWait();
    csN = 1'h0;
    if (startHigh) begin
      halfWait();
      sclk = 1'h0;
    end
    for (int c = 0; c < n; c++) begin
      word = ctrlQ.pop_front();
      for (int k = 1; k <= 16; k++) begin
        din = (k <= 8) ? word[8-k] : ~din;
        halfWait();
        bits = {bits[14:0], pinDout};
        sclk = 1'h1;
        halfWait();
        if (k == stopAt) begin
          csN = 1'h1;
          halfWait();
          sclk = 1'h0;
          return;
        end
        if (!(k == 16 && c == n - 1)) sclk = 1'h0;
      end
      frameQ.push_back(bits);
    end
    // release the frame while the clock is high, then park it low
    csN = 1'h1;
    halfWait();
    sclk = 1'h0;
    halfWait();
  endtask
endmodule

/* bench/adc_serial_ctrl_tb.sv */
// self-checking bench for the converter serial control
`timescale 1ns/1ps
module adc_serial_ctrl_tb;
  import adc_ctrl_pkg::*;
  logic clock, rst, csN, sclk, din, dout, doutOeN, muxSelect, tracking;
  logic powered, sampleValid, sampleReady;
  logic pwPrev = 1'h0;
  logic [RES_BITS-1:0] sampleData;
  wire pinDout;
  int errorCnt, checkCount;
  int trkLen = 0;
  int pdCnt = 0;
  int gap = 0;
  logic muxQ[$];
  int trkQ[$];
  int gapQ[$];
  // channel expected per conversion, lsb first; all later ones first input
  localparam logic [6:0] CH_EXP = 7'h4a;
  // released output floats, so a stray read shows up as z
  assign pinDout = doutOeN ? 1'bz : dout;
  always #50 clock = ~clock;
  adc_serial_ctrl DUT (.clock(clock), .rst(rst), .csN(csN), .sclk(sclk),
    .din(din), .dout(dout), .doutOeN(doutOeN), .muxSelect(muxSelect),
    .tracking(tracking), .powered(powered), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady));
  host_port_model host (.clock(clock), .csN(csN), .sclk(sclk), .din(din),
    .pinDout(pinDout));
  // per conversion: channel, start spacing, track length, power drops
  // falling edge: registered outputs have settled by then
  always @(negedge clock) begin
    gap++;
    if (tracking === 1'h1) begin
      if (trkLen == 0) begin
        muxQ.push_back(muxSelect);
        gapQ.push_back(gap);
        gap = 0;
      end
      trkLen++;
    end else if (trkLen != 0) begin
      trkQ.push_back(trkLen);
      trkLen = 0;
    end
    if (csN === 1'h0 && pwPrev === 1'h1 && powered === 1'h0) pdCnt++;
    pwPrev = powered;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [11:0] word(input int i);
    return (i == 31) ? 12'hfff : 12'(i * 133);
  endfunction
  // main sequence
  initial begin
    clock = 1'h0;
    rst = 1'h1;
    sampleData = 12'h000;
    sampleValid = 1'h0;
    errorCnt = 0;
    checkCount = 0;
    repeat (12) @(negedge clock);
    check(doutOeN, 1'h1);
    check(powered, 1'h0);
    check(muxSelect, 1'h0);
    check(sampleReady, 1'h1);
    rst = 1'h0;
    // fill the buffer to refusal and keep offering past it
    for (int i = 0; i < 35; i++) begin
      sampleData = (i < 32) ? word(i) : 12'h5a5;
      sampleValid = 1'h1;
      @(negedge clock);
    end
    check(sampleReady, 1'h0);
    sampleValid = 1'h0;
    // ignored bits set in every way; middle select bit never set
    host.ctrlQ = '{8'h08, 8'hc7, 8'h2f, 8'he4};
    host.runFrame(4, 1'b0, 0);
    repeat (8) @(negedge clock);
    check(doutOeN, 1'h1);
    check(powered, 1'h0);
    check(sampleReady, 1'h1);
    // cut before the word is whole: selection must stay
    host.ctrlQ = '{8'h08};
    host.runFrame(1, 1'b0, 2);
    repeat (8) @(negedge clock);
    check(doutOeN, 1'h1);
    host.ctrlQ = '{8'h0f, 8'h00};
    host.runFrame(2, 1'b1, 0);
    // drain the buffer dry in one long frame
    for (int i = 0; i < 27; i++) host.ctrlQ.push_back(8'h00);
    host.runFrame(27, 1'b0, 0);
    repeat (8) @(negedge clock);
    check(16'(host.frameQ.size()), 16'h0021);
    // buffer words in order, then code zero once it has run dry
    foreach (host.frameQ[i])
      check(host.frameQ[i], (i < 32) ? 16'(word(i)) : '0);
    check(16'(muxQ.size()), 16'h0022);
    foreach (muxQ[i])
      check(muxQ[i], (i < 7) ? 16'(CH_EXP[i]) : '0);
    check(16'(trkQ.size()), 16'h0022);
    foreach (trkQ[i])
      check(16'(trkQ[i]), (i == 4) ? 16'h0018 : 16'h0024);
    check(16'(gapQ.size()), 16'h0022);
    // frame starts are spaced freely; the rest follow at 16 serial clocks
    foreach (gapQ[i])
      if (!(i inside {0, 4, 5, 7})) check(16'(gapQ[i]), 16'h00c0);
    check(16'(pdCnt), 16'h0021);
    testDone();
  end
  // watchdog: the run needs about 6500 clocks
  initial begin
    repeat (20000) @(posedge clock);
    errorCnt++;
    testDone();
  end
endmodule
